/* File: rtl/aof_consts.svh */
/*
 Offsets, field positions, reset values and fixed words of the serial output formatter.
 Assumes inclusion by bare name from the formatter's design file.
*/
`ifndef AOF_CONSTS_SVH
`define AOF_CONSTS_SVH

`define AOF_ADDR_CTRL 8'h00
`define AOF_ADDR_TEST 8'h04
`define AOF_ADDR_HDR 8'h08
`define AOF_ADDR_STAT 8'h0C

`define AOF_CTRL_FMT_LSB 0
`define AOF_CTRL_INV_BIT 2
`define AOF_CTRL_LSBF_BIT 3
`define AOF_CTRL_LOWBW_BIT 4
`define AOF_CTRL_SYNC_BIT 5
`define AOF_TEST_LEN_LSB 8
`define AOF_STAT_DATA_BIT 0
`define AOF_STAT_UNDR_BIT 1

`define AOF_HDR_RST 8'h00
`define AOF_LEN_RST 4'hC
`define AOF_LEN_MIN 4'h8
`define AOF_LEN_MAX 4'hE

`define AOF_PKT_BITS 64
`define AOF_SAMPLES 4
`define AOF_ECC_LOW 7'h00
`define AOF_TRAIN_PKT 64'h66A5_3553_DDBB_CCAA

`define AOF_W_MID 14'h2000
`define AOF_W_ONES 14'h3FFF
`define AOF_W_CHK_A 14'h2AAA
`define AOF_W_CHK_B 14'h1555

`define AOF_PN9_SEED 9'h0DF
`define AOF_PN23_SEED 23'h29B80A

`define AOF_RESP_OKAY 2'b00
`define AOF_RESP_SLVERR 2'b10

`endif

/* File: rtl/aof_pkg.sv */
/*
 Types shared by the serial output formatter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package aof_pkg;
	typedef enum logic [1:0] {
		AOF_FMT_OFFBIN = 2'h0,
		AOF_FMT_TWOS = 2'h1,
		AOF_FMT_GRAY = 2'h2
	} aof_fmt_e;

	typedef enum logic [3:0] {
		AOF_TM_OFF = 4'h0,
		AOF_TM_MID = 4'h1,
		AOF_TM_PFS = 4'h2,
		AOF_TM_NFS = 4'h3,
		AOF_TM_CHK = 4'h4,
		AOF_TM_PNL = 4'h5,
		AOF_TM_PNS = 4'h6,
		AOF_TM_TGL = 4'h7
	} aof_tmode_e;
endpackage

/* File: rtl/aof_formatter.sv */
/*
 Sample FIFO and the per-lane packet formatter with its AXI4-Lite register slave.
 Assumes converter samples arrive on ref_clk_i; the sync pin is asynchronous.
*/
`timescale 1ns/1ns
`include "aof_consts.svh"

module aof_fifo #(
	parameter int W = 12,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("fifo depth must be a power of two");
	end

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rp_q];
	assign out_valid_o = cnt_q != '0;

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			in_ready_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			in_ready_o <= cnt_d != DEPTH[AW:0];
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push)
			mem_q[wp_q] <= in_data_i;
	end
endmodule

module aof_formatter
	import aof_pkg::*;
#(
	parameter int SW = 12,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [11:0] sample_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	input wire logic sync_i,
	output logic serial_o,
	output logic pll_low_bw_o
);
	initial begin
		if (SW != 12)
			$error("packet layout serves 12 bit samples only");
	end

	// register state
	logic [1:0] fmt_q;
	logic [3:0] tmode_q, len_q;
	logic [7:0] hdr_q;
	logic inv_q, lsbf_q, sync_soft_q, undr_q, data_mode_q;
	// bus slave state
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rd_val;
	logic [3:0] wstrb_q;
	logic wr_go, wr_hit, rd_hit, undr_clr;
	// datapath state
	logic sync_m_q, sync_s_q;
	logic [63:0] shift_q, pkt_d;
	logic [5:0] bitcnt_q;
	logic [11:0] samp_q [`AOF_SAMPLES];
	logic [11:0] fifo_data;
	logic [2:0] have_q;
	logic [8:0] pn9_q, pn9_d;
	logic [22:0] pn23_q, pn23_d;
	logic boundary, synced, test_on, discard, use_data, fifo_valid, fifo_pop;

	function automatic logic [11:0] fmt_word(input logic [11:0] ob, input logic [1:0] f);
		if (f == AOF_FMT_TWOS)
			return {~ob[11], ob[10:0]};
		if (f == AOF_FMT_GRAY)
			return ob ^ {1'b0, ob[11:1]};
		return ob;
	endfunction

	// returns next state in the upper bits and the 12 bit word in the lower
	function automatic logic [20:0] pn9_step(input logic [8:0] s);
		logic [8:0] st;
		logic [11:0] w;
		st = s;
		w = '0;
		for (int i = 0; i < 12; i++) begin
			w = {w[10:0], st[7]};
			st = {st[7:0], st[8] ^ st[4]};
		end
		return {st, w};
	endfunction

	function automatic logic [34:0] pn23_step(input logic [22:0] s);
		logic [22:0] st;
		logic [11:0] w;
		st = s;
		w = '0;
		for (int i = 0; i < 12; i++) begin
			w = {w[10:0], ~st[21]};
			st = {st[21:0], st[22] ^ st[17]};
		end
		return {st, w};
	endfunction

	aof_fifo #(
		.W(12),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.in_data_i(sample_i),
		.in_valid_i(sample_valid_i),
		.in_ready_o(sample_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop)
	);

	// AXI4-Lite write path: address and data taken in either order
	assign wr_go = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	assign wr_hit = awaddr_q == `AOF_ADDR_CTRL || awaddr_q == `AOF_ADDR_TEST ||
		awaddr_q == `AOF_ADDR_HDR || awaddr_q == `AOF_ADDR_STAT;
	assign undr_clr = wr_go && awaddr_q == `AOF_ADDR_STAT && wstrb_q[0] && wdata_q[`AOF_STAT_UNDR_BIT];

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `AOF_RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				awaddr_q <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_hit ? `AOF_RESP_OKAY : `AOF_RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			fmt_q <= AOF_FMT_OFFBIN;
			inv_q <= 1'b0;
			lsbf_q <= 1'b0;
			pll_low_bw_o <= 1'b0;
			sync_soft_q <= 1'b0;
			tmode_q <= AOF_TM_OFF;
			len_q <= `AOF_LEN_RST;
			hdr_q <= `AOF_HDR_RST;
		end else if (wr_go) begin
			if (awaddr_q == `AOF_ADDR_CTRL && wstrb_q[0]) begin
				fmt_q <= wdata_q[`AOF_CTRL_FMT_LSB +: 2];
				inv_q <= wdata_q[`AOF_CTRL_INV_BIT];
				lsbf_q <= wdata_q[`AOF_CTRL_LSBF_BIT];
				pll_low_bw_o <= wdata_q[`AOF_CTRL_LOWBW_BIT];
				sync_soft_q <= wdata_q[`AOF_CTRL_SYNC_BIT];
			end else if (awaddr_q == `AOF_ADDR_TEST) begin
				if (wstrb_q[0])
					tmode_q <= wdata_q[3:0];
				if (wstrb_q[1])
					len_q <= wdata_q[`AOF_TEST_LEN_LSB +: 4];
			end else if (awaddr_q == `AOF_ADDR_HDR && wstrb_q[0]) begin
				hdr_q <= wdata_q[7:0];
			end
		end
	end

	// read path: one cycle from address taken to rvalid
	always_comb begin
		rd_hit = 1'b1;
		rd_val = '0;
		if (s_axi_araddr_i == `AOF_ADDR_CTRL) begin
			rd_val = {26'h0, sync_soft_q, pll_low_bw_o, lsbf_q, inv_q, fmt_q};
		end else if (s_axi_araddr_i == `AOF_ADDR_TEST) begin
			rd_val = {20'h0, len_q, 4'h0, tmode_q};
		end else if (s_axi_araddr_i == `AOF_ADDR_HDR) begin
			rd_val = {24'h0, hdr_q};
		end else if (s_axi_araddr_i == `AOF_ADDR_STAT) begin
			rd_val = {30'h0, undr_q, data_mode_q};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= '0;
			s_axi_rresp_o <= `AOF_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_val;
			s_axi_rresp_o <= rd_hit ? `AOF_RESP_OKAY : `AOF_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// sync pin is asynchronous to the sample clock
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			sync_m_q <= 1'b0;
			sync_s_q <= 1'b0;
		end else begin
			sync_m_q <= sync_i;
			sync_s_q <= sync_m_q;
		end
	end

	assign boundary = bitcnt_q == 6'd63;
	assign synced = sync_s_q || sync_soft_q;
	assign test_on = tmode_q != AOF_TM_OFF;
	// converter data is drained and dropped while it cannot be sent, so the source never locks up
	assign discard = !synced || test_on;
	assign use_data = synced && !test_on && have_q == 3'd4;
	assign fifo_pop = fifo_valid && (discard || have_q != 3'd4 || boundary);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			have_q <= '0;
			for (int i = 0; i < `AOF_SAMPLES; i++)
				samp_q[i] <= '0;
		end else if (discard) begin
			have_q <= '0;
		end else if (boundary && use_data) begin
			have_q <= {2'b00, fifo_pop};
			if (fifo_pop)
				samp_q[0] <= fifo_data;
		end else if (fifo_pop) begin
			samp_q[have_q[1:0]] <= fifo_data;
			have_q <= have_q + 3'd1;
		end
	end

	// packet assembly
	always_comb begin
		logic [13:0] mask;
		logic [11:0] w [`AOF_SAMPLES];
		logic [20:0] r9;
		logic [34:0] r23;
		logic [63:0] raw;
		mask = `AOF_W_ONES << 2; // lengths outside 8..14 fall back to 12 bits
		for (int i = 0; i < `AOF_SAMPLES; i++)
			w[i] = '0;
		r9 = '0;
		r23 = '0;
		raw = '0;
		pn9_d = pn9_q;
		pn23_d = pn23_q;
		if (len_q >= `AOF_LEN_MIN && len_q <= `AOF_LEN_MAX)
			mask = `AOF_W_ONES << (5'd14 - {1'b0, len_q});
		for (int i = 0; i < `AOF_SAMPLES; i++) begin
			case (tmode_q)
				AOF_TM_MID: w[i] = fmt_word(12'(`AOF_W_MID >> 2), fmt_q);
				AOF_TM_PFS: w[i] = fmt_word(mask[13:2], fmt_q);
				AOF_TM_NFS: w[i] = fmt_word(12'h000, fmt_q);
				AOF_TM_CHK: w[i] = i % 2 == 0 ? 12'(`AOF_W_CHK_A & mask >> 2) : 12'(`AOF_W_CHK_B & mask >> 2);
				AOF_TM_TGL: w[i] = i % 2 == 0 ? mask[13:2] : 12'h000;
				AOF_TM_PNS: begin
					r9 = pn9_step(pn9_d);
					pn9_d = r9[20:12];
					w[i] = fmt_word(r9[11:0], fmt_q);
				end
				AOF_TM_PNL: begin
					r23 = pn23_step(pn23_d);
					pn23_d = r23[34:12];
					w[i] = fmt_word(r23[11:0], fmt_q);
				end
				default: w[i] = fmt_word(samp_q[i], fmt_q);
			endcase
		end
		if (!synced || (!test_on && !use_data))
			raw = `AOF_TRAIN_PKT;
		else
			raw = {hdr_q, w[0], w[1], w[2], w[3], 1'b0, `AOF_ECC_LOW};
		pkt_d = raw;
		if (lsbf_q) begin
			for (int b = 0; b < `AOF_PKT_BITS; b++)
				pkt_d[b] = raw[`AOF_PKT_BITS-1-b];
		end
		if (inv_q)
			pkt_d = ~pkt_d;
	end

	// one bit per clock, one packet per four sample periods
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			bitcnt_q <= 6'd63;
			shift_q <= '0;
			serial_o <= 1'b0;
			data_mode_q <= 1'b0;
		end else begin
			bitcnt_q <= bitcnt_q + 6'd1;
			serial_o <= shift_q[63];
			if (boundary) begin
				shift_q <= pkt_d;
				data_mode_q <= synced && (test_on || use_data);
			end else begin
				shift_q <= {shift_q[62:0], 1'b0};
			end
		end
	end

	// generators restart from their seeds whenever their mode is left
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			pn9_q <= `AOF_PN9_SEED;
			pn23_q <= `AOF_PN23_SEED;
		end else begin
			if (tmode_q != AOF_TM_PNS || !synced)
				pn9_q <= `AOF_PN9_SEED;
			else if (boundary)
				pn9_q <= pn9_d;
			if (tmode_q != AOF_TM_PNL || !synced)
				pn23_q <= `AOF_PN23_SEED;
			else if (boundary)
				pn23_q <= pn23_d;
		end
	end

	// underrun is sticky; a new underrun beats a clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i)
			undr_q <= 1'b0;
		else if (boundary && synced && !test_on && !use_data)
			undr_q <= 1'b1;
		else if (undr_clr)
			undr_q <= 1'b0;
	end
endmodule

/* File: test/aof_lane_rx.sv */
/*
 Serial lane receiver model: gathers 64-bit packets and drives the sync pin.
 Assumes the first packet bit shows two edges after reset release.
*/
`timescale 1ns/1ns
module aof_lane_rx (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic serial_i,
	input wire logic sync_en_i,
	output logic sync_o,
	output logic [63:0] pkt_o,
	output logic pkt_evt_o
);
	logic [1:0] live_q = 2'h0;
	logic [5:0] cnt_q;
	logic [63:0] sh_q;
	initial sync_o = 1'b0;
	always @(posedge ref_clk_i) begin
		live_q <= resetn_i ? {live_q[0], 1'b1} : 2'h0;
		// a receiver only declares lock once it has seen a training packet
		sync_o <= resetn_i && sync_en_i && (sync_o || pkt_o === 64'h66A5_3553_DDBB_CCAA);
	end
	// sample mid-bit so the design's flop update has settled
	always @(negedge ref_clk_i) begin
		pkt_evt_o <= 1'b0;
		if (!live_q[1]) begin
			cnt_q <= 6'h00;
		end else begin
			sh_q <= {sh_q[62:0], serial_i};
			cnt_q <= cnt_q + 6'h01;
			if (cnt_q == 6'h3F) begin
				pkt_o <= {sh_q[62:0], serial_i};
				pkt_evt_o <= 1'b1;
			end
		end
	end
endmodule

/* File: test/aof_formatter_asserts.sv */
/*
 Register bus and control checks of the serial output formatter.
 Assumes binding to aof_formatter; one clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
module aof_formatter_asserts (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic pll_low_bw_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	logic wr_go;
	assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	property p_wr_resp; wr_go |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response not two cycles after take");
	property p_wr_block; wr_go |=> (!s_axi_awready_o && !s_axi_wready_o) [*2]; endproperty
	a_wr_block: assert property (p_wr_block) else $error("write channel ready while busy");
	property p_b_done; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o; endproperty
	a_b_done: assert property (p_b_done) else $error("write response not retired");
	property p_wr_err; wr_go && s_axi_awaddr_i >= 8'h10 |-> ##2 s_axi_bresp_o == 2'h2; endproperty
	a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
	property p_rd_resp; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer not next cycle");
	property p_r_done; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o; endproperty
	a_r_done: assert property (p_r_done) else $error("read response not retired");
	property p_rd_err;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i >= 8'h10 |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
	property p_pll_bw;
		wr_go && s_axi_awaddr_i == 8'h00 && s_axi_wstrb_i[0] |-> ##2 pll_low_bw_o == $past(s_axi_wdata_i[4], 2);
	endproperty
	a_pll_bw: assert property (p_pll_bw) else $error("low bandwidth output not following control");
endmodule
bind aof_formatter aof_formatter_asserts u_asserts (.*);

/* File: test/aof_formatter_tb.sv */
/*
 Self-checking bench of the serial output formatter with a lane receiver model.
 Assumes the formatter loads a packet every 64 clocks from the first edge after reset.
*/
`timescale 1ns/1ns
module aof_formatter_tb;
	localparam logic [63:0] TRAIN = 64'h66A5_3553_DDBB_CCAA;
	logic ref_clk_i = 1'b0, resetn_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic sample_valid_i = 1'b0, sync_en = 1'b0, full_seen = 1'b0;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0] s_axi_wstrb_i = 4'h0;
	logic [11:0] sample_i = 12'h000;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic sample_ready_o, sync_i, serial_o, pll_low_bw_o, pkt_evt;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o;
	logic [63:0] pkt;
	logic [11:0] sq[$];
	logic [11:0] sv4[4] = '{12'h000, 12'h800, 12'hFFF, 12'h123};
	int miscompares = 0, samples_checked = 0, cyc = 0;

	always #50 ref_clk_i = ~ref_clk_i;
	aof_formatter dut (.*);
	aof_lane_rx rx (.ref_clk_i, .resetn_i, .serial_i(serial_o), .sync_en_i(sync_en), .sync_o(sync_i),
		.pkt_o(pkt), .pkt_evt_o(pkt_evt));

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// the whole run needs about 3000 cycles
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 9000) begin
			miscompares++;
			final_report();
		end
	end
	// converter side: offers the queue head, stalls whenever the fifo refuses
	always @(posedge ref_clk_i) begin
		if (sample_valid_i && sample_ready_o)
			void'(sq.pop_front());
		if (sample_valid_i && !sample_ready_o)
			full_seen <= 1'b1;
		sample_valid_i <= sq.size() > 0;
		if (sq.size() > 0)
			sample_i <= sq[0];
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
		@(posedge ref_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= st;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		chk(s_axi_bresp_o, er);
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge ref_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		chk(s_axi_rdata_o, e);
		chk(s_axi_rresp_o, er);
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic skip(input int n);
		repeat (n) @(posedge pkt_evt);
	endtask
	// settings made just after a packet land in the second packet from here
	task automatic pk(input logic [63:0] e);
		skip(2);
		chk(pkt, e);
	endtask
	function automatic logic [63:0] pf(input int f);
		logic [11:0] x[4];
		foreach (x[i]) x[i] = f == 1 ? sv4[i] ^ 12'h800 : f == 2 ? sv4[i] ^ (sv4[i] >> 1) : sv4[i];
		return {8'hA7, x[0], x[1], x[2], x[3], 8'h00};
	endfunction

	task automatic t_reset();
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h04, 32'h0000_0C00, 2'h0);
		rd(8'h10, 32'h0, 2'h2);
		wr(8'h14, 32'h1, 4'h1, 2'h2);
		skip(1);
		chk(pkt, TRAIN);
		chk(pll_low_bw_o, 1'b0);
		$display("done reset");
	endtask
	task automatic t_data();
		sync_en <= 1'b1;
		wr(8'h08, 32'hA7, 4'h1, 2'h0);
		skip(3);
		// sixteen samples: four collected, eight fill the fifo, the rest must stall
		sq = {sv4[0], sv4[1], sv4[2], sv4[3], 12'h456, 12'h789, 12'hABC, 12'hDEF, 12'h111, 12'h222, 12'h333, 12'h444,
			12'h555, 12'h666, 12'h777, 12'h888};
		pk(pf(0));
		skip(1);
		chk(pkt, 64'hA7_456789ABCDEF_00);
		skip(1);
		chk(pkt, 64'hA7_111222333444_00);
		// last load carried data; the idle synced packets before it left underrun set
		rd(8'h0C, 32'h3, 2'h0);
		skip(1);
		chk(pkt, 64'hA7_555666777888_00);
		chk(full_seen, 1'b1);
		wr(8'h0C, 32'h2, 4'h1, 2'h0);
		rd(8'h0C, 32'h0, 2'h0);
		$display("done data");
	endtask
	task automatic t_format();
		for (int f = 1; f < 4; f++) begin
			foreach (sv4[i]) sq.push_back(sv4[i]);
			wr(8'h00, f, 4'h1, 2'h0);
			pk(pf(f));
		end
		$display("done format");
	endtask
	task automatic t_pattern();
		logic [35:0] tab[5] = '{36'h11C000000, 36'h21C7FF7FF, 36'h31C800800, 36'h428AA0550, 36'h72EFFF000};
		foreach (tab[i]) begin
			wr(8'h00, tab[i][31:28], 4'h1, 2'h0);
			wr(8'h04, {tab[i][27:24], 4'h0, tab[i][35:32]}, 4'h3, 2'h0);
			pk({8'hA7, {2{tab[i][23:0]}}, 8'h00});
		end
		$display("done pattern");
	endtask
	task automatic t_pn();
		logic [39:0] pn[2] = '{40'h6DF9353301, 40'h5591FD70A3};
		wr(8'h00, 32'h0, 4'h1, 2'h0);
		foreach (pn[i]) begin
			wr(8'h04, {4'hC, 4'h0, pn[i][39:36]}, 4'h3, 2'h0);
			skip(2);
			chk(pkt[55:20], pn[i][35:0]);
		end
		$display("done pn");
	endtask
	task automatic t_wire();
		logic [63:0] p = {8'hA7, {4{12'h800}}, 8'h00};
		logic [63:0] pr;
		logic [31:0] pc[4] = '{32'h14, 32'h08, 32'h0C, 32'h00};
		pr = {<<{p}};
		wr(8'h04, 32'h0000_0C01, 4'h3, 2'h0);
		foreach (pc[i]) begin
			wr(8'h00, pc[i], 4'h1, 2'h0);
			pk((pc[i][3] ? pr : p) ^ {64{pc[i][2]}});
			chk(pll_low_bw_o, pc[i][4]);
		end
		sync_en <= 1'b0;
		skip(3);
		chk(pkt, TRAIN);
		sync_en <= 1'b1;
		skip(3);
		chk(pkt, p);
		// software sync must keep the mid-scale test pattern flowing once the pin drops
		sync_en <= 1'b0;
		wr(8'h00, 32'h20, 4'h1, 2'h0);
		pk(p);
		$display("done wire");
	endtask

	initial begin
		repeat (10) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_data();
		t_format();
		t_pattern();
		t_pn();
		t_wire();
		final_report();
	end
endmodule
